// ==== core/nfc_ctrl.sv ====
// nand flash host controller on strobed pins
// assumes pin inputs are asynchronous and the user side shares core_clk
`timescale 1ns/1ps
`default_nettype none
`include "nfc_cfg.svh"
module nfc_ctrl #(
   parameter int FIFO_DEPTH = 16
) (
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst,
   // user command port
   input  wire logic               cmdValid,
   output logic                    cmdReady,
   input  wire nfc_pkg::nfc_cmd_s  cmd,
   input  wire logic               otpMode,
   // program data stream
   input  wire logic [7:0]         wrData,
   input  wire logic               wrValid,
   output logic                    wrReady,
   // read data stream
   output logic [7:0]              rdData,
   output logic                    rdValid,
   // completion
   output logic                    doneValid,
   output var nfc_pkg::nfc_done_s  done,
   // device pins
   output var nfc_pkg::nfc_pins_s  pins,
   input  wire logic [7:0]         dqIn,
   input  wire logic               rbN
);
   import nfc_pkg::*;

   localparam logic [7:0] STB = 8'(`NFC_STROBE_CYC - 1);
   localparam logic [7:0] WHR = 8'(`NFC_WHR_CYC);
   localparam logic [7:0] WB  = 8'(`NFC_WB_CYC);
   localparam int         PB  = `NFC_PAGE_BITS;

   if (FIFO_DEPTH < 2) begin : g_chk
      $error("fifo depth below two");
   end

   ////////////////////////////////////////////////////////////////////////////
   // program data fifo
   logic [7:0] fifoData;
   logic       fifoValid, fifoPop;

   nfc_fifo #(.DW(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk (core_clk),
      .rst      (rst),
      .inData   (wrData),
      .inValid  (wrValid),
      .inReady  (wrReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (fifoPop)
   );

   ////////////////////////////////////////////////////////////////////////////
   // strobe rate divider and pin synchronisers
   logic [7:0] div_r, div_nxt;
   logic [8:0] s1_r, s1_nxt, s2_r, s2_nxt, s3_r, s3_nxt;
   logic       rbRdy_r, rbRdy_nxt, tick, dqStable;

   assign tick     = div_r == 8'h00;
   assign dqStable = s2_r[7:0] == s3_r[7:0];

   // ready only counts once stages two and three agree
   always_comb begin
      div_nxt   = tick ? STB : div_r - 8'h01;
      s1_nxt    = {rbN, dqIn};
      s2_nxt    = s1_r;
      s3_nxt    = s2_r;
      rbRdy_nxt = (s2_r[8] == s3_r[8]) ? s3_r[8] : rbRdy_r; // R9
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_r   <= 8'h00;
         s1_r    <= 9'h000;
         s2_r    <= 9'h000;
         s3_r    <= 9'h000;
         rbRdy_r <= 1'b0;
      end else begin
         div_r   <= div_nxt;
         s1_r    <= s1_nxt;
         s2_r    <= s2_nxt;
         s3_r    <= s3_nxt;
         rbRdy_r <= rbRdy_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   nfc_state_e  st_r, st_nxt;
   nfc_op_e     op_r, op_nxt;
   nfc_pins_s   pins_r, pins_nxt;
   nfc_done_s   done_r, done_nxt;
   logic [7:0]  c1_r, c1_nxt, c2_r, c2_nxt, wait_r, wait_nxt;
   logic [7:0]  rdData_r, rdData_nxt, busByte;
   logic [39:0] addr_r, addr_nxt;
   logic [2:0]  nAddr_r, nAddr_nxt, part_r, part_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic [23:0] lastRow_r, lastRow_nxt;
   logic        hasC2_r, hasC2_nxt, waitB_r, waitB_nxt, statM_r, statM_nxt;
   logic        stcCmd_r, stcCmd_nxt, resume_r, resume_nxt, trk_r, trk_nxt;
   logic        rdValid_r, rdValid_nxt, doneV_r, doneV_nxt, cmdRdy_r;
   logic        busSt, startCyc, endCyc, sameBlk, samePg, refuse;

   // bus cycle: strobe low one tick, high one tick
   always_comb begin
      case (st_r)
         S_CMD, S_ADR, S_CNF, S_TAIL, S_RD: busSt = 1'b1;
         S_WR:    busSt = cnt_r != 16'h0000;
         S_STC:   busSt = stcCmd_r;
         default: busSt = 1'b0;
      endcase
      case (st_r)
         S_CMD:   busByte = c1_r;
         S_ADR:   busByte = addr_r[7:0];
         S_WR:    busByte = fifoData;
         S_CNF:   busByte = c2_r;
         S_STC:   busByte = `NFC_CMD_STAT;
         default: busByte = `NFC_CMD_RDMODE;
      endcase
   end

   // data waits on the fifo; a read sample waits for a settled bus
   assign startCyc = busSt && tick && pins_r.weN && pins_r.reN && (st_r != S_WR || fifoValid);
   assign endCyc   = busSt && tick && (!pins_r.weN || !pins_r.reN)
                     && (st_r != S_RD || dqStable);
   assign fifoPop  = startCyc && st_r == S_WR;

   // order and partial checks on a fresh program, and no 78h in otp mode
   assign sameBlk = trk_r && cmd.row[23:PB] == lastRow_r[23:PB];
   assign samePg  = sameBlk && cmd.row[PB-1:0] == lastRow_r[PB-1:0];
   assign refuse  = (cmd.op == OP_STATE && otpMode) // R12
                 || (cmd.op == OP_PROG && cmd.newPage
                     && ((sameBlk && cmd.row[PB-1:0] < lastRow_r[PB-1:0])  // R15
                         || (samePg && part_r == `NFC_PART_MAX))); // R16

   always_comb begin
      st_nxt      = st_r;
      op_nxt      = op_r;
      pins_nxt    = pins_r;
      done_nxt    = done_r;
      c1_nxt      = c1_r;
      c2_nxt      = c2_r;
      wait_nxt    = wait_r;
      rdData_nxt  = rdData_r;
      addr_nxt    = addr_r;
      nAddr_nxt   = nAddr_r;
      part_nxt    = part_r;
      cnt_nxt     = cnt_r;
      lastRow_nxt = lastRow_r;
      hasC2_nxt   = hasC2_r;
      waitB_nxt   = waitB_r;
      statM_nxt   = statM_r;
      stcCmd_nxt  = stcCmd_r;
      resume_nxt  = resume_r;
      trk_nxt     = trk_r;
      rdValid_nxt = 1'b0;
      doneV_nxt   = 1'b0;
      // pin drive: set on the falling strobe, raise next tick
      if (startCyc) begin
         pins_nxt.ceN   = 1'b0;
         pins_nxt.cle   = st_r inside {S_CMD, S_CNF, S_STC, S_TAIL};
         pins_nxt.ale   = st_r == S_ADR;
         pins_nxt.weN   = st_r == S_RD;
         pins_nxt.reN   = st_r != S_RD;
         pins_nxt.dqOeN = st_r == S_RD;
         pins_nxt.dq    = busByte;
      end else if (endCyc) begin
         pins_nxt.weN = 1'b1;
         pins_nxt.reN = 1'b1;
      end else if (!busSt) begin
         pins_nxt.cle   = 1'b0;
         pins_nxt.ale   = 1'b0;
         pins_nxt.dqOeN = 1'b1;
         pins_nxt.ceN   = st_r inside {S_IDLE, S_DONE};
      end
      case (st_r)
         S_IDLE: begin
            if (cmdValid) begin
               op_nxt     = cmd.op;
               cnt_nxt    = cmd.count;
               resume_nxt = cmd.resume;
               addr_nxt   = {cmd.row, cmd.col};
               hasC2_nxt  = 1'b0;
               waitB_nxt  = 1'b0;
               statM_nxt  = 1'b0;
               stcCmd_nxt = 1'b0;
               nAddr_nxt  = 3'h0;
               c2_nxt     = `NFC_CMD_COLEND;
               done_nxt   = '0;
               case (cmd.op)
                  OP_ID: begin
                     c1_nxt    = `NFC_CMD_ID; // R1 R2
                     nAddr_nxt = 3'h1;
                     addr_nxt  = {32'h0, cmd.col[7:0]};
                  end
                  OP_PARAM, OP_UID: begin
                     c1_nxt    = (cmd.op == OP_PARAM) ? `NFC_CMD_PARAM
                                                      : `NFC_CMD_UID;      // R3 R14
                     nAddr_nxt = 3'h1;
                     addr_nxt  = '0;
                     waitB_nxt = 1'b1;
                  end
                  OP_STAT: begin
                     c1_nxt    = `NFC_CMD_STAT; // R4
                     statM_nxt = 1'b1;
                  end
                  OP_STATE: begin
                     c1_nxt    = `NFC_CMD_STATE; // R10
                     nAddr_nxt = 3'h3;
                     addr_nxt  = {16'h0000, cmd.row};
                     statM_nxt = 1'b1;
                  end
                  OP_RDMODE: c1_nxt = `NFC_CMD_RDMODE; // R5
                  OP_COLRD: begin
                     c1_nxt    = `NFC_CMD_COLRD; // R22
                     nAddr_nxt = 3'h2;
                     hasC2_nxt = 1'b1;
                  end
                  default: begin
                     c1_nxt     = cmd.newPage ? `NFC_CMD_PROG : `NFC_CMD_RNDIN; // R19
                     nAddr_nxt  = cmd.newPage ? 3'h5 : 3'h2; // R17
                     hasC2_nxt  = cmd.cnf != CNF_NONE;
                     c2_nxt     = (cmd.cnf == CNF_CACHE) ? `NFC_CMD_CACHE
                                                         : `NFC_CMD_CNF;   // R20
                     waitB_nxt  = cmd.cnf != CNF_NONE;
                     statM_nxt  = cmd.cnf != CNF_NONE;
                     stcCmd_nxt = cmd.cnf != CNF_NONE;
                  end
               endcase
               if (refuse) begin
                  done_nxt.err = 1'b1;
                  st_nxt       = S_DONE;
               end else begin
                  st_nxt = S_CMD;
                  if (cmd.op == OP_PROG && cmd.newPage) begin
                     trk_nxt     = 1'b1;
                     lastRow_nxt = cmd.row;
                     part_nxt    = samePg ? part_r + 3'h1 : 3'h1; // R16
                  end
               end
            end
         end
         S_CMD: begin
            if (endCyc) begin
               st_nxt   = (nAddr_r != 3'h0) ? S_ADR : S_STC;
               wait_nxt = WHR;
            end
         end
         S_ADR: begin
            if (endCyc) begin
               addr_nxt  = {8'h00, addr_r[39:8]};
               nAddr_nxt = nAddr_r - 3'h1;
               wait_nxt  = WHR;
               if (nAddr_r == 3'h1) begin
                  if (op_r == OP_PROG) st_nxt = S_WR;
                  else if (hasC2_r) st_nxt = S_CNF;
                  else if (waitB_r) st_nxt = S_BUSY;
                  else st_nxt = S_STC;
               end
            end
         end
         S_WR: begin
            // one byte per strobe; an empty fifo stalls the bus
            if (cnt_r == 16'h0000) begin
               st_nxt = hasC2_r ? S_CNF : S_DONE;
            end else if (endCyc) begin
               cnt_nxt = cnt_r - 16'h0001; // R17
            end
         end
         S_CNF: begin
            if (endCyc) begin
               st_nxt   = waitB_r ? S_BUSY : S_STC;
               wait_nxt = waitB_r ? WB : WHR;
            end
         end
         S_BUSY: begin
            // nothing issued while busy
            if (wait_r != 8'h00) begin
               wait_nxt = wait_r - 8'h01;
            end else if (rbRdy_r) begin // R18 R21
               st_nxt   = S_STC;
               wait_nxt = WHR;
            end
         end
         S_STC: begin
            if (stcCmd_r) begin
               if (endCyc) begin
                  stcCmd_nxt = 1'b0; // R18
                  wait_nxt   = WHR;
               end
            end else if (wait_r != 8'h00) begin
               wait_nxt = wait_r - 8'h01;
            end else begin
               st_nxt = (statM_r || cnt_r != 16'h0000) ? S_RD : S_DONE;
            end
         end
         S_RD: begin
            if (endCyc) begin
               if (statM_r) begin
                  done_nxt.status = s3_r[7:0]; // R6 R7 R8
                  if (op_r == OP_STATE && !s3_r[`NFC_SR_CACHE_RDY]) begin
                     st_nxt = S_RD; // R13
                  end else if (op_r == OP_STATE && resume_r) begin
                     st_nxt = S_TAIL; // R13
                  end else begin
                     st_nxt = S_DONE;
                  end
               end else begin
                  rdData_nxt  = s3_r[7:0];
                  rdValid_nxt = 1'b1;
                  cnt_nxt     = cnt_r - 16'h0001;
                  if (cnt_r == 16'h0001) st_nxt = S_DONE;
               end
            end
         end
         S_TAIL: begin
            if (endCyc) st_nxt = S_DONE;
         end
         S_DONE: begin
            doneV_nxt = 1'b1;
            st_nxt    = S_IDLE;
         end
         default: st_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_r      <= S_IDLE;
         op_r      <= OP_ID;
         pins_r    <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00};
         done_r    <= '0;
         c1_r      <= 8'h00;
         c2_r      <= 8'h00;
         wait_r    <= 8'h00;
         rdData_r  <= 8'h00;
         addr_r    <= '0;
         nAddr_r   <= 3'h0;
         part_r    <= 3'h0;
         cnt_r     <= 16'h0000;
         lastRow_r <= '0;
         hasC2_r   <= 1'b0;
         waitB_r   <= 1'b0;
         statM_r   <= 1'b0;
         stcCmd_r  <= 1'b0;
         resume_r  <= 1'b0;
         trk_r     <= 1'b0;
         rdValid_r <= 1'b0;
         doneV_r   <= 1'b0;
         cmdRdy_r  <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         op_r      <= op_nxt;
         pins_r    <= pins_nxt;
         done_r    <= done_nxt;
         c1_r      <= c1_nxt;
         c2_r      <= c2_nxt;
         wait_r    <= wait_nxt;
         rdData_r  <= rdData_nxt;
         addr_r    <= addr_nxt;
         nAddr_r   <= nAddr_nxt;
         part_r    <= part_nxt;
         cnt_r     <= cnt_nxt;
         lastRow_r <= lastRow_nxt;
         hasC2_r   <= hasC2_nxt;
         waitB_r   <= waitB_nxt;
         statM_r   <= statM_nxt;
         stcCmd_r  <= stcCmd_nxt;
         resume_r  <= resume_nxt;
         trk_r     <= trk_nxt;
         rdValid_r <= rdValid_nxt;
         doneV_r   <= doneV_nxt;
         cmdRdy_r  <= st_nxt == S_IDLE && !(st_r == S_IDLE && cmdValid);
      end
   end

   // all user and pin outputs straight from flops
   assign cmdReady  = cmdRdy_r;
   assign rdData    = rdData_r;
   assign rdValid   = rdValid_r;
   assign doneValid = doneV_r;
   assign done      = done_r;
   assign pins      = pins_r;

endmodule : nfc_ctrl
`default_nettype wire

// ==== core/nfc_cfg.svh ====
// nand host constants: commands, timing, status bits
// assumes a 250 MHz core clock and one device on the strobed pins
//
// Notes on behaviour
// R1 - 90h, 00h: five id bytes
// R2 - 90h, 20h: four signature bytes
// R3 - ECh streams parameter page
// R4 - 70h: status while strobe low
// R5 - status mode until 00h
// R6 - bits 2-4 zero, 7 protect, 1 previous
// R7 - bit 0 program fail
// R8 - bit 5 low while array busy
// R9 - bit 6 cache ready, pin mirrors
// R10 - 78h, three row cycles
// R11 - 78h bits 6,5 device, 1,0 plane
// R12 - no 78h in otp mode
// R13 - after 78h wait bit6, 00h
// R14 - unique id plus complement, repeated
// R15 - pages ascending, no bit twice
// R16 - four partial programs per page
// R17 - 80h, five addresses, data, 10h
// R18 - while busy only 70h or FFh
// R19 - 85h changes column before confirm
// R20 - 15h busy until cache free
// R21 - cache program waits previous
// R22 - 05h, two columns, E0h
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH

`define NFC_CMD_ID      8'h90
`define NFC_CMD_PARAM   8'hEC
`define NFC_CMD_UID     8'hED
`define NFC_CMD_STAT    8'h70
`define NFC_CMD_STATE   8'h78
`define NFC_CMD_RDMODE  8'h00
`define NFC_CMD_COLRD   8'h05
`define NFC_CMD_COLEND  8'hE0
`define NFC_CMD_PROG    8'h80
`define NFC_CMD_RNDIN   8'h85
`define NFC_CMD_CNF     8'h10
`define NFC_CMD_CACHE   8'h15

`define NFC_CLK_MHZ     250
`define NFC_T_STROBE_NS 25
`define NFC_T_WHR_NS    80
`define NFC_T_WB_NS     100
`define NFC_STROBE_CYC  ((`NFC_T_STROBE_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_WHR_CYC     ((`NFC_T_WHR_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_WB_CYC      ((`NFC_T_WB_NS * `NFC_CLK_MHZ + 999) / 1000)

`define NFC_SR_CACHE_RDY 6
`define NFC_PAGE_BITS   6
`define NFC_PART_MAX    3'h4

`endif

// ==== core/nfc_pkg.sv ====
// types shared by the nand host controller and its user
// types use fixed widths and need nothing from the constants header
package nfc_pkg;

   typedef enum logic [2:0] {
      OP_ID, OP_PARAM, OP_UID, OP_STAT, OP_STATE, OP_RDMODE, OP_COLRD, OP_PROG
   } nfc_op_e;

   typedef enum logic [1:0] {CNF_NONE, CNF_PAGE, CNF_CACHE} nfc_cnf_e;

   // gray along the usual path
   typedef enum logic [3:0] {
      S_IDLE = 4'h0, S_CMD = 4'h1, S_ADR = 4'h3, S_WR = 4'h2, S_CNF = 4'h6,
      S_BUSY = 4'h7, S_STC = 4'h5, S_RD = 4'h4, S_TAIL = 4'hC, S_DONE = 4'hD
   } nfc_state_e;

   typedef struct packed {
      nfc_op_e     op;
      logic        newPage;
      nfc_cnf_e    cnf;
      logic        resume;
      logic [15:0] col;
      logic [23:0] row;
      logic [15:0] count;
   } nfc_cmd_s;

   typedef struct packed {
      logic       ceN;
      logic       cle;
      logic       ale;
      logic       weN;
      logic       reN;
      logic       dqOeN;
      logic [7:0] dq;
   } nfc_pins_s;

   typedef struct packed {
      logic [7:0] status;
      logic       err;
   } nfc_done_s;

endpackage : nfc_pkg

// ==== core/nfc_fifo.sv ====
// small synchronous fifo for program data
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module nfc_fifo #(
   parameter int DW    = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst,
   // fill side
   input  wire logic [DW-1:0] inData,
   input  wire logic          inValid,
   output logic               inReady,
   // drain side
   output logic [DW-1:0]      outData,
   output logic               outValid,
   input  wire logic          outReady
);
   localparam int AW = $clog2(DEPTH);

   // pointer arithmetic wraps, so only powers of two are served
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("depth not a power of two");
   end

   logic [DW-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]   cnt_r, cnt_nxt;
   logic          full_r, full_nxt, empty_r, empty_nxt;
   logic          push, pop;

   assign push     = inValid && !full_r;
   assign pop      = outReady && !empty_r;
   assign inReady  = !full_r;
   assign outValid = !empty_r;
   assign outData  = mem_r[rp_r];

   // pointers and flags held in flops so ready is clean
   always_comb begin
      wp_nxt    = push ? wp_r + 1'b1 : wp_r;
      rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt   = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      full_nxt  = cnt_nxt == (AW+1)'(DEPTH);
      empty_nxt = cnt_nxt == '0;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wp_r    <= '0;
         rp_r    <= '0;
         cnt_r   <= '0;
         full_r  <= 1'b0;
         empty_r <= 1'b1;
      end else begin
         wp_r    <= wp_nxt;
         rp_r    <= rp_nxt;
         cnt_r   <= cnt_nxt;
         full_r  <= full_nxt;
         empty_r <= empty_nxt;
      end
   end

   // storage needs no reset, reads are gated by empty
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_r[wp_r] <= inData;
      end
   end

endmodule : nfc_fifo
`default_nettype wire

// ==== bench/nfc_ctrl_properties.sv ====
// port checks for the nand host controller
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module nfc_ctrl_properties #(
   parameter int FIFO_DEPTH = 16
) (
   // clock and reset
   input wire logic               core_clk,
   input wire logic               rst,
   // user side
   input wire logic               cmdValid,
   input wire logic               cmdReady,
   input wire nfc_pkg::nfc_cmd_s  cmd,
   input wire logic               otpMode,
   input wire logic               doneValid,
   input wire nfc_pkg::nfc_done_s done,
   // device side
   input wire nfc_pkg::nfc_pins_s pins,
   input wire logic               rbN
);
   import nfc_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire take = cmdValid && cmdReady;
   ////////////////////
   // idle straight after reset
   property p_reset_idle; $fell(rst) |-> pins.ceN && pins.weN && pins.reN && !cmdReady; endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("reset pins");
   property p_done_pulse; doneValid |=> !doneValid; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done long");
   property p_take_drop; take |=> !cmdReady; endproperty
   a_take_drop: assert property (p_take_drop) else $error("ready held");
   // refused request stays off the pins
   property p_otp_refuse; take && otpMode && cmd.op == OP_STATE |=> pins.ceN ##1
      (pins.ceN && doneValid && done.err); endproperty
   a_otp_refuse: assert property (p_otp_refuse) else $error("otp 78h");
   property p_we_width; $fell(pins.weN) |-> (!pins.weN) [*7] ##1 pins.weN; endproperty
   a_we_width: assert property (p_we_width) else $error("we width");
   property p_re_width; $fell(pins.reN) |-> (!pins.reN) [*7] ##1 pins.reN; endproperty
   a_re_width: assert property (p_re_width) else $error("re width");
   // busy: only status or reset
   property p_busy_cmd; $fell(pins.weN) && !rbN |-> pins.cle && pins.dq inside {8'h70, 8'hFF};
   endproperty
   a_busy_cmd: assert property (p_busy_cmd) else $error("busy cmd");
   property p_read_release; !pins.reN |-> pins.dqOeN; endproperty
   a_read_release: assert property (p_read_release) else $error("read drive");
   property p_write_drive; !pins.weN |-> !pins.dqOeN; endproperty
   a_write_drive: assert property (p_write_drive) else $error("write float");
   property p_lone_phase; !pins.cle || !pins.ale; endproperty
   a_lone_phase: assert property (p_lone_phase) else $error("cle ale");
   c_refused: cover property (doneValid && done.err);
   c_failed: cover property (doneValid && done.status[0]);
   c_ready: cover property ($rose(rbN));
endmodule : nfc_ctrl_properties
bind nfc_ctrl nfc_ctrl_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.core_clk(core_clk),
   .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd), .otpMode(otpMode),
   .doneValid(doneValid), .done(done), .pins(pins), .rbN(rbN));
`default_nettype wire

// ==== bench/nfc_flash_model.sv ====
// event driven nand flash answering the controller pins
// assumes strobes only; the model has no clock
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model #(
   parameter int         BUSY_NS  = 2000,
   parameter int         CACHE_NS = 300,
   parameter logic [7:0] ID_BASE  = 8'hA0, // arbitrary value
   parameter logic [7:0] SIG_BASE = 8'hC0  // arbitrary value
) (
   // host pins and program fail control
   input  wire nfc_pkg::nfc_pins_s pins,
   input  wire logic               failMode,
   // device answers
   output var logic [7:0]          dqIn,
   output var logic                rbN
);
   import nfc_pkg::*;
   logic [7:0]  mode, adr, lastWr;
   logic [15:0] col;
   logic        arrRdy, curFail, prevFail;
   int          idx, wrCnt;
   event        goPage, goCache;
   wire  [7:0]  status = {1'h1, rbN, arrRdy, 3'h0, prevFail, curFail};
   initial begin
      {rbN, arrRdy, curFail, prevFail} = 4'hC;
      {mode, adr, lastWr, col} = '0;
      dqIn = 8'h5A;
      idx = 0;
      wrCnt = 0;
   end
   ////////////////////
   // latch on the rising write strobe
   always @(posedge pins.weN) begin
      if (!pins.ceN && pins.cle) begin
         mode = pins.dq;
         idx = 0;
         if (pins.dq inside {8'h00, 8'hEC}) col = '0;
         if (pins.dq == 8'h80) wrCnt = 0;
         if (pins.dq inside {8'h10, 8'h15}) {prevFail, curFail} = {curFail, failMode};
         if (pins.dq == 8'h10) ->goPage;
         if (pins.dq == 8'h15) ->goCache;
      end else if (!pins.ceN && pins.ale) begin
         adr = pins.dq;
         col = {pins.dq, col[15:8]};
      end else if (!pins.ceN) begin
         wrCnt++;
         lastWr = pins.dq;
      end
   end
   // cache frees early while the array works
   always @(goPage) begin
      {rbN, arrRdy} = 2'h0;
      #(BUSY_NS);
      {rbN, arrRdy} = 2'h3;
   end
   always @(goCache) begin
      {rbN, arrRdy} = 2'h0;
      #(CACHE_NS);
      rbN = 1'h1;
      #(BUSY_NS - CACHE_NS);
      arrRdy = 1'h1;
   end
   // a released bus never keeps the last byte
   always @(negedge pins.reN) begin
      #6;
      if (pins.ceN) dqIn = ~dqIn;
      else if (mode inside {8'h70, 8'h78, 8'h10, 8'h15}) dqIn = status;
      else if (mode == 8'h90) dqIn = (adr == 8'h20 ? SIG_BASE : ID_BASE) + 8'(idx);
      else dqIn = col[7:0];
   end
   always @(posedge pins.reN) begin
      idx++;
      col++;
      #4;
      dqIn = ~dqIn;
   end
endmodule : nfc_flash_model
`default_nettype wire

// ==== bench/test_nfc_ctrl.sv ====
// self-checking bench for the nand host controller
// assumes the flash model on the pins and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; $display( \
   "wrong value at %0t: got %0h expected %0h", $time, a, b); end end
module test_nfc_ctrl;
   import nfc_pkg::*;
   typedef struct packed {
      nfc_op_e     op;
      logic [15:0] col;
      logic [7:0]  n, first, step;
   } nfc_row_s;
   logic       core_clk, rst, cmdValid, cmdReady, otpMode, wrValid, wrReady;
   logic       rdValid, doneValid, rbN, failMode, r;
   logic [7:0] wrData, rdData, dqIn;
   nfc_cmd_s   cmd;
   nfc_done_s  done;
   nfc_pins_s  pins;
   int         fail_count, checked, n, i, k;
   logic [7:0] got[$];
   // reads: count, first byte, step
   nfc_row_s rows [5] = '{
      '{OP_ID, 16'h0, 8'h05, 8'hA0, 8'h01}, '{OP_ID, 16'h20, 8'h04, 8'hC0, 8'h01},
      '{OP_COLRD, 16'h10, 8'h02, 8'h10, 8'h01}, '{OP_RDMODE, 16'h0, 8'h02, 8'h00, 8'h01},
      '{OP_PARAM, 16'h0, 8'h03, 8'h00, 8'h01}};
   nfc_ctrl #(.FIFO_DEPTH(16)) dut (.core_clk(core_clk), .rst(rst), .cmdValid(cmdValid),
      .cmdReady(cmdReady), .cmd(cmd), .otpMode(otpMode), .wrData(wrData), .wrValid(wrValid),
      .wrReady(wrReady), .rdData(rdData), .rdValid(rdValid), .doneValid(doneValid),
      .done(done), .pins(pins), .dqIn(dqIn), .rbN(rbN));
   nfc_flash_model flash (.pins(pins), .failMode(failMode), .dqIn(dqIn), .rbN(rbN));
   initial begin
      core_clk = 1'h0;
      forever #2 core_clk = ~core_clk;
   end
   ////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   function automatic nfc_cmd_s mk(nfc_op_e op, logic [23:0] row, logic [15:0] c,
                                   logic [15:0] cnt, nfc_cnf_e cf, logic np);
      return '{op, np, cf, 1'h1, c, row, cnt};
   endfunction : mk
   // one request; a hang is a mismatch
   task automatic run(input nfc_cmd_s c);
      got.delete();
      @(posedge core_clk);
      cmd <= c;
      cmdValid <= 1'h1;
      for (i = 0; i < 100; i++) begin
         @(negedge core_clk);
         if (cmdReady) break;
      end
      if (i == 100) fail_count++;
      @(posedge core_clk);
      cmdValid <= 1'h0;
      for (i = 0; i < 20000; i++) begin
         @(negedge core_clk);
         if (rdValid) got.push_back(rdData);
         if (doneValid) break;
      end
      if (i == 20000) begin
         fail_count++;
         finish_test();
      end
   endtask : run
   // offer kk bytes, n counts those taken
   task automatic fill(input int kk);
      @(posedge core_clk);
      n = 0;
      wrData <= 8'h00;
      wrValid <= 1'h1;
      repeat (kk) begin
         @(negedge core_clk);
         r = wrReady;
         @(posedge core_clk);
         if (r) n++;
         wrData <= 8'(n);
      end
      wrValid <= 1'h0;
   endtask : fill
   initial begin
      {rst, cmdValid, otpMode, wrValid, failMode} = 5'h10;
      cmd = '0;
      wrData = 8'h00;
      fail_count = 0;
      checked = 0;
      repeat (8) @(posedge core_clk);
      rst <= 1'h0;
      @(negedge core_clk);
      `CHK({pins.ceN, pins.weN, pins.reN, pins.dqOeN, cmdReady}, 5'h1E)
      foreach (rows[j]) begin
         run(mk(rows[j].op, 24'h0, rows[j].col, 16'(rows[j].n), CNF_NONE, 1'h0));
         `CHK(got.size(), int'(rows[j].n))
         foreach (got[m]) `CHK(got[m], rows[j].first + rows[j].step * 8'(m))
      end
      run(mk(OP_STAT, 24'h0, 16'h0, 16'h1, CNF_NONE, 1'h0));
      `CHK(done.status, 8'hE0)
      fill(20);
      `CHK({n[7:0], wrReady}, 9'h020)
      run(mk(OP_PROG, 24'h41, 16'h0, 16'h10, CNF_PAGE, 1'h1));
      `CHK({done.status, done.err, wrReady}, 10'h381)
      `CHK({flash.wrCnt[7:0], flash.lastWr}, 16'h100F)
      failMode <= 1'h1;
      fill(2);
      run(mk(OP_PROG, 24'h42, 16'h0, 16'h2, CNF_PAGE, 1'h1));
      `CHK({done.status, done.err}, 9'h1C2)
      failMode <= 1'h0;
      fill(1);
      run(mk(OP_PROG, 24'h43, 16'h0, 16'h1, CNF_CACHE, 1'h1));
      `CHK(done.status, 8'hC2)
      for (k = 0; k < 4; k++) begin
         run(mk(OP_PROG, 24'h43, 16'h0, 16'h0, CNF_PAGE, 1'h1));
         `CHK(done.err, k == 3)
      end
      run(mk(OP_PROG, 24'h40, 16'h0, 16'h0, CNF_PAGE, 1'h1));
      `CHK(done.err, 1'h1)
      otpMode <= 1'h1;
      run(mk(OP_STATE, 24'h43, 16'h0, 16'h1, CNF_NONE, 1'h0));
      `CHK(done.err, 1'h1)
      otpMode <= 1'h0;
      run(mk(OP_STATE, 24'h43, 16'h0, 16'h1, CNF_NONE, 1'h0));
      `CHK({done.status, done.err}, 9'h1C0)
      finish_test();
   end
endmodule : test_nfc_ctrl
`default_nettype wire
